/* File: mlp_pkg.sv */
// Shared constants and types for the memory load port and its host end
package mlp_pkg;
   // Register numbers on the load link
   localparam logic [7:0]  REG_STATUS    = 8'h02;
   localparam logic [7:0]  REG_HEADER    = 8'h04;
   localparam logic [7:0]  REG_PAYLOAD   = 8'h05;

   // Header and payload framing
   localparam logic [2:0]  HDR_LAST_IDX  = 3'h7;
   localparam logic [15:0] TERM_CSUM     = 16'h0000;
   localparam logic [15:0] TERM_ADDR     = 16'h0000;
   localparam logic [15:0] TERM_COUNT    = 16'h0000;
   localparam int          HDR_CSUM_MSB  = 63;
   localparam int          HDR_MEM_LSB   = 40;
   localparam int          HDR_ADDR_LSB  = 16;
   localparam int          HDR_COUNT_LSB = 0;

   // Target memory codes; codes above MEM_LAST are reserved
   localparam logic [3:0]  MEM_MCU_PROG  = 4'h0;
   localparam logic [3:0]  MEM_MCU_XDATA = 4'h1;
   localparam logic [3:0]  MEM_DSP_PROG  = 4'h2;
   localparam logic [3:0]  MEM_DSP_COEF  = 4'h3;
   localparam logic [3:0]  MEM_DSP_DATA  = 4'h4;
   localparam logic [3:0]  MEM_UP_DATA   = 4'h5;
   localparam logic [3:0]  MEM_UP_COEF   = 4'h6;
   localparam logic [3:0]  MEM_LAST      = 4'h6;

   // Word sizes in bytes and data masks per memory width
   localparam logic [3:0]  WB_BYTES_8    = 4'h1;
   localparam logic [3:0]  WB_BYTES_28   = 4'h4;
   localparam logic [3:0]  WB_BYTES_WIDE = 4'h8;
   localparam logic [63:0] MASK_8        = 64'h0000_0000_0000_00FF;
   localparam logic [63:0] MASK_28       = 64'h0000_0000_0FFF_FFFF;
   localparam logic [63:0] MASK_48       = 64'h0000_FFFF_FFFF_FFFF;
   localparam logic [63:0] MASK_54       = 64'h003F_FFFF_FFFF_FFFF;

   // Status low byte layout and fixed codes
   localparam int          ST_MCU_PROG   = 0;
   localparam int          ST_MCU_XDATA  = 1;
   localparam int          ST_DSP_PROG   = 2;
   localparam int          ST_UP_COEF    = 3;
   localparam int          ST_UP_DATA    = 4;
   localparam int          ST_BAD_SEL    = 5;
   localparam int          ST_FLAGS      = 6;
   localparam logic [5:0]  FLAGS_RST     = 6'h00;
   localparam logic [7:0]  ST_END_HDR_ERR = 8'hF0;
   localparam logic [7:0]  ST_DIV_REPORT = 8'hFF;
   localparam logic [1:0]  ST_PAD        = 2'h0;
   localparam int          FW_CLR_TERM   = 6;

   // Host command register layout
   localparam logic [7:0]  WB_CMD        = 8'h00;
   localparam logic [7:0]  WB_RXDATA     = 8'h04;
   localparam logic [7:0]  WB_IRQ_STAT   = 8'h08;
   localparam logic [7:0]  WB_IRQ_MASK   = 8'h0C;
   localparam logic [7:0]  WB_STATE      = 8'h10;
   localparam int          CMD_DATA_LSB  = 0;
   localparam int          CMD_ADDR_LSB  = 8;
   localparam int          CMD_OP_LSB    = 16;
   localparam int          IRQ_DONE      = 0;
   localparam int          IRQ_RX        = 1;
   localparam int          IRQ_OVERRUN   = 2;
   localparam int          IRQ_BITS      = 3;
   localparam logic [2:0]  IRQ_RST       = 3'h0;

   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_WRITE = 2'h1,
      OP_READ  = 2'h2
   } mlp_op_t;
endpackage

/* File: mlp_link_if.sv */
// Byte-level register link between the system host and the load port
`timescale 1ns/1ps
`default_nettype none
interface mlp_link_if;
   logic       xfer_start;
   logic [7:0] reg_addr;
   logic       wr_stb;
   logic [7:0] wdata;
   logic       rd_stb;
   logic       rd_valid;
   logic [7:0] rdata;

   modport host (
      output xfer_start, reg_addr, wr_stb, wdata, rd_stb,
      input  rd_valid, rdata
   );
   modport dev (
      input  xfer_start, reg_addr, wr_stb, wdata, rd_stb,
      output rd_valid, rdata
   );
endinterface
`default_nettype wire

/* File: mlp_device.sv */
// Memory load port: header/payload unpacking, checksum and load status
//
// Behaviour
// RQ1: Load start or error sets memory flag
// RQ2: Successful load clears that memory's flag
// RQ3: Host reads status after every load
// RQ4: Firmware may also clear the flags
// RQ5: Status low byte: flags, codes; high firmware
// RQ6: All-ones low byte reports clock divider
// RQ7: Host loads memories over the slave port
// RQ8: Eight-byte header register, eight-byte data register
// RQ9: Header first, then payload in groups
// RQ10: Two checksum bytes close the transfer
// RQ11: Header checksum; termination carries zero
// RQ12: Header byte three selects target memory
// RQ13: Address and count; zero on termination
// RQ14: Byte memories take one byte each
// RQ15: 28-bit words packed four bytes each
// RQ16: Wide words one per group, MSB first
// RQ17: Checksum sits in final two bytes
// RQ18: Zero address and count ends session
// RQ19: Checksum mismatch keeps error flag set
`timescale 1ns/1ps
`default_nettype none
module mlp_device (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   mlp_link_if.dev          link,
   output logic             mem_we_o,
   output logic [3:0]       mem_sel_o,
   output logic [15:0]      mem_addr_o,
   output logic [63:0]      mem_wdata_o,
   input  wire logic [6:0]  fw_clr_i,
   input  wire logic [23:0] fw_status_hi_i,
   input  wire logic        fw_div_report_i,
   output logic             load_active_o,
   output logic             load_done_o,
   output logic             load_ok_o,
   output logic             session_end_o
);
   import mlp_pkg::*;

   typedef enum logic [1:0] {
      LD_IDLE = 2'b00,
      LD_DATA = 2'b01,
      LD_CSUM = 2'b11
   } mlp_ld_t;

   mlp_ld_t     state_r;
   logic [7:0]  cur_reg_r;
   logic [2:0]  hdr_idx_r;
   logic [55:0] hdr_r;
   logic [63:0] hdr_full;
   logic        hdr_wr;
   logic        pay_wr;
   logic        hdr_done;
   logic        is_term;
   logic        bad_sel;
   logic [3:0]  sel_r;
   logic [15:0] addr_r;
   logic [15:0] left_r;
   logic [15:0] sum_r;
   logic [15:0] sum_nxt;
   logic [55:0] asm_r;
   logic [3:0]  wbyte_r;
   logic [3:0]  word_bytes;
   logic [63:0] word_mask;
   logic [7:0]  csum_hi_r;
   logic        csum_idx_r;
   logic        csum_end;
   logic        csum_ok;
   logic [5:0]  flags_r;
   logic [5:0]  flag_set;
   logic [5:0]  flag_ok_clr;
   logic        term_err_r;
   logic [31:0] status;
   logic [7:0]  status_lo;
   logic [1:0]  rd_idx_r;

   // Memory code to status bit; coefficient and data share the upper bits
   function automatic int unsigned flag_bit(input logic [3:0] sel);
      unique case (sel)
         MEM_MCU_PROG:                return ST_MCU_PROG;
         MEM_MCU_XDATA:               return ST_MCU_XDATA;
         MEM_DSP_PROG:                return ST_DSP_PROG;
         MEM_DSP_COEF, MEM_UP_COEF:   return ST_UP_COEF;
         MEM_DSP_DATA, MEM_UP_DATA:   return ST_UP_DATA;
         default:                     return ST_BAD_SEL;
      endcase
   endfunction

   // Sum of header bytes three to eight
   function automatic logic [15:0] hdr_sum(input logic [63:0] h);
      logic [15:0] s;
      s = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         s = s + {8'h00, h[i*8 +: 8]};
      end
      return s;
   endfunction

   assign hdr_wr   = link.wr_stb && (cur_reg_r == REG_HEADER);
   assign pay_wr   = link.wr_stb && (cur_reg_r == REG_PAYLOAD);
   assign hdr_full = {hdr_r, link.wdata};
   assign hdr_done = hdr_wr && (hdr_idx_r == HDR_LAST_IDX);
   // RQ13: header field decode
   assign is_term  = (hdr_full[HDR_ADDR_LSB +: 16] == TERM_ADDR) &&
                     (hdr_full[HDR_COUNT_LSB +: 16] == TERM_COUNT);
   // RQ12: reserved memory codes
   assign bad_sel  = hdr_full[HDR_MEM_LSB +: 4] > MEM_LAST ||
                     hdr_full[HDR_MEM_LSB + 4 +: 4] != 4'h0;
   assign sum_nxt  = sum_r + {8'h00, link.wdata};
   assign csum_end = link.wr_stb && (cur_reg_r == REG_PAYLOAD) &&
                     (state_r == LD_CSUM) && csum_idx_r;
   // RQ19: compare closing checksum with running sum
   assign csum_ok  = ({csum_hi_r, link.wdata} == sum_r);

   // RQ15: word size and width per target memory
   // RQ16: wide memories take one word per group
   always_comb begin
      unique case (sel_r)
         MEM_MCU_PROG, MEM_MCU_XDATA: begin
            word_bytes = WB_BYTES_8;
            word_mask  = MASK_8;
         end
         MEM_DSP_COEF, MEM_UP_COEF: begin
            word_bytes = WB_BYTES_28;
            word_mask  = MASK_28;
         end
         MEM_DSP_PROG: begin
            word_bytes = WB_BYTES_WIDE;
            word_mask  = MASK_54;
         end
         default: begin
            word_bytes = WB_BYTES_WIDE;
            word_mask  = MASK_48;
         end
      endcase
   end

   // Register selected by the last transfer start
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_reg_r <= 8'h00;
      end else if (link.xfer_start) begin
         cur_reg_r <= link.reg_addr;
      end
   end

   // RQ8: header bytes collected in order
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hdr_idx_r <= 3'h0;
         hdr_r     <= 56'h0;
      end else if (link.xfer_start) begin
         hdr_idx_r <= 3'h0;
      end else if (hdr_wr) begin
         hdr_idx_r <= hdr_idx_r + 3'h1;
         hdr_r     <= hdr_full[55:0];
      end
   end

   // RQ9: load sequencing, header then payload then checksum
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r    <= LD_IDLE;
         sel_r      <= MEM_MCU_PROG;
         addr_r     <= 16'h0000;
         left_r     <= 16'h0000;
         sum_r      <= 16'h0000;
         csum_hi_r  <= 8'h00;
         csum_idx_r <= 1'b0;
      end else if (hdr_done) begin
         sel_r      <= hdr_full[HDR_MEM_LSB +: 4];
         addr_r     <= hdr_full[HDR_ADDR_LSB +: 16];
         left_r     <= hdr_full[HDR_COUNT_LSB +: 16];
         sum_r      <= hdr_sum(hdr_full);
         csum_idx_r <= 1'b0;
         // RQ18: termination or bad select starts no load
         if (is_term || bad_sel) begin
            state_r <= LD_IDLE;
         end else if (hdr_full[HDR_COUNT_LSB +: 16] == 16'h0000) begin
            state_r <= LD_CSUM;
         end else begin
            state_r <= LD_DATA;
         end
      end else if (pay_wr) begin
         unique case (state_r)
            LD_DATA: begin
               sum_r  <= sum_nxt;
               left_r <= left_r - 16'h0001;
               if (left_r == 16'h0001) begin
                  state_r <= LD_CSUM;
               end
            end
            // RQ17: last two bytes are the checksum
            LD_CSUM: begin
               csum_hi_r  <= link.wdata;
               csum_idx_r <= ~csum_idx_r;
               if (csum_idx_r) begin
                  state_r <= LD_IDLE;
               end
            end
            LD_IDLE: begin
               state_r <= LD_IDLE;
            end
            default: begin
               state_r <= LD_IDLE;
            end
         endcase
      end else if (state_r == 2'b10) begin
         state_r <= LD_IDLE;
      end
   end

   // RQ14: bytes assembled into memory words and written
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         asm_r       <= 56'h0;
         wbyte_r     <= 4'h0;
         mem_we_o    <= 1'b0;
         mem_sel_o   <= MEM_MCU_PROG;
         mem_addr_o  <= 16'h0000;
         mem_wdata_o <= 64'h0;
      end else begin
         mem_we_o <= 1'b0;
         if (hdr_done) begin
            wbyte_r <= 4'h0;
         end else if (pay_wr && state_r == LD_DATA) begin
            asm_r <= {asm_r[47:0], link.wdata};
            if (wbyte_r + 4'h1 == word_bytes) begin
               wbyte_r     <= 4'h0;
               mem_we_o    <= 1'b1;
               mem_sel_o   <= sel_r;
               mem_addr_o  <= addr_r;
               mem_wdata_o <= {asm_r, link.wdata} & word_mask;
            end else begin
               wbyte_r <= wbyte_r + 4'h1;
            end
         end
      end
   end

   // Load activity follows the sequencer, one cycle late
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_active_o <= 1'b0;
      end else begin
         load_active_o <= (state_r != LD_IDLE);
      end
   end

   // RQ1: start of a load or a failed check sets the flag
   always_comb begin
      flag_set    = FLAGS_RST;
      flag_ok_clr = FLAGS_RST;
      if (hdr_done && !is_term) begin
         flag_set[flag_bit(hdr_full[HDR_MEM_LSB +: 4])] = 1'b1;
         if (bad_sel) begin
            flag_set[ST_BAD_SEL] = 1'b1;
         end
      end
      if (csum_end) begin
         if (csum_ok) begin
            // RQ2: good checksum clears the flag
            flag_ok_clr[flag_bit(sel_r)] = 1'b1;
         end else begin
            flag_set[flag_bit(sel_r)] = 1'b1;
         end
      end
   end

   // RQ4: firmware clears; a hardware set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_r <= FLAGS_RST;
      end else begin
         flags_r <= (flags_r & ~fw_clr_i[ST_FLAGS-1:0] & ~flag_ok_clr) | flag_set;
      end
   end

   // RQ11: termination header must carry a zero checksum
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         term_err_r <= 1'b0;
      end else if (hdr_done && is_term) begin
         term_err_r <= (hdr_full[HDR_CSUM_MSB -: 16] != TERM_CSUM);
      end else if (fw_clr_i[FW_CLR_TERM]) begin
         term_err_r <= 1'b0;
      end
   end

   // RQ10: completion pulses when the checksum or a termination header lands
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_done_o   <= 1'b0;
         load_ok_o     <= 1'b0;
         session_end_o <= 1'b0;
      end else begin
         load_done_o   <= csum_end;
         load_ok_o     <= csum_end && csum_ok;
         session_end_o <= hdr_done && is_term;
      end
   end

   // RQ5: status layout
   // RQ6: divider report overrides the low byte
   always_comb begin
      if (fw_div_report_i) begin
         status_lo = ST_DIV_REPORT;
      end else if (term_err_r) begin
         status_lo = ST_END_HDR_ERR;
      end else begin
         status_lo = {ST_PAD, flags_r};
      end
      status = {fw_status_hi_i, status_lo};
   end

   // RQ3: status bytes returned most significant first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_idx_r      <= 2'h0;
         link.rd_valid <= 1'b0;
         link.rdata    <= 8'h00;
      end else begin
         link.rd_valid <= link.rd_stb;
         if (link.xfer_start) begin
            rd_idx_r <= 2'h0;
         end else if (link.rd_stb) begin
            rd_idx_r <= rd_idx_r + 2'h1;
            if (cur_reg_r == REG_STATUS) begin
               link.rdata <= status[(2'h3 - rd_idx_r)*8 +: 8];
            end else begin
               link.rdata <= 8'h00;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: mlp_host.sv */
// Host end: Wishbone command registers driving the load link
`timescale 1ns/1ps
`default_nettype none
module mlp_host (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   mlp_link_if.host         link
);
   import mlp_pkg::*;

   typedef enum logic [1:0] {
      HS_IDLE  = 2'b00,
      HS_ISSUE = 2'b01,
      HS_WAIT  = 2'b11
   } mlp_hs_t;

   mlp_hs_t              state_r;
   mlp_op_t              op_r;
   logic                 req;
   logic                 cmd_wr;
   logic [7:0]           rx_r;
   logic [IRQ_BITS-1:0]  stat_r;
   logic [IRQ_BITS-1:0]  mask_r;
   logic [IRQ_BITS-1:0]  ev;
   logic [31:0]          wmask;
   logic [31:0]          rd_mux;

   assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign cmd_wr = req && wb_we_i && (wb_adr_i == WB_CMD) && (wb_sel_i == 4'hF);
   assign irq_o  = |(stat_r & mask_r);

   // Byte lanes expanded to a bit mask
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= rd_mux;
         end
      end
   end

   always_comb begin
      unique case (wb_adr_i)
         WB_RXDATA:   rd_mux = {24'h0, rx_r};
         WB_IRQ_STAT: rd_mux = {29'h0, stat_r};
         WB_IRQ_MASK: rd_mux = {29'h0, mask_r};
         WB_STATE:    rd_mux = {31'h0, state_r != HS_IDLE};
         default:     rd_mux = 32'h0;
      endcase
   end

   // RQ9: each command accepted in HS_IDLE becomes one link operation
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r         <= HS_IDLE;
         op_r            <= OP_START;
         link.xfer_start <= 1'b0;
         link.wr_stb     <= 1'b0;
         link.rd_stb     <= 1'b0;
         link.reg_addr   <= 8'h00;
         link.wdata      <= 8'h00;
         rx_r            <= 8'h00;
      end else begin
         link.xfer_start <= 1'b0;
         link.wr_stb     <= 1'b0;
         link.rd_stb     <= 1'b0;
         unique case (state_r)
            HS_IDLE: begin
               if (cmd_wr) begin
                  op_r    <= mlp_op_t'(wb_dat_i[CMD_OP_LSB +: 2]);
                  state_r <= HS_ISSUE;
                  unique case (wb_dat_i[CMD_OP_LSB +: 2])
                     OP_START: begin
                        link.xfer_start <= 1'b1;
                        link.reg_addr   <= wb_dat_i[CMD_ADDR_LSB +: 8];
                     end
                     OP_WRITE: begin
                        link.wr_stb <= 1'b1;
                        link.wdata  <= wb_dat_i[CMD_DATA_LSB +: 8];
                     end
                     default: begin
                        link.rd_stb <= 1'b1;
                     end
                  endcase
               end
            end
            HS_ISSUE: begin
               state_r <= (op_r == OP_READ) ? HS_WAIT : HS_IDLE;
            end
            // RQ3: status byte captured for software
            HS_WAIT: begin
               if (link.rd_valid) begin
                  rx_r    <= link.rdata;
                  state_r <= HS_IDLE;
               end
            end
            default: begin
               state_r <= HS_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      ev              = IRQ_RST;
      ev[IRQ_DONE]    = (state_r == HS_ISSUE && op_r != OP_READ) ||
                        (state_r == HS_WAIT && link.rd_valid);
      ev[IRQ_RX]      = (state_r == HS_WAIT && link.rd_valid);
      ev[IRQ_OVERRUN] = cmd_wr && (state_r != HS_IDLE);
   end

   // Sticky events, write one to clear, set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_r <= IRQ_RST;
         mask_r <= IRQ_RST;
      end else begin
         if (req && wb_we_i && wb_adr_i == WB_IRQ_STAT) begin
            stat_r <= (stat_r & ~(wb_dat_i[IRQ_BITS-1:0] & wmask[IRQ_BITS-1:0])) | ev;
         end else begin
            stat_r <= stat_r | ev;
         end
         if (req && wb_we_i && wb_adr_i == WB_IRQ_MASK) begin
            mask_r <= (mask_r & ~wmask[IRQ_BITS-1:0]) |
                      (wb_dat_i[IRQ_BITS-1:0] & wmask[IRQ_BITS-1:0]);
         end
      end
   end
endmodule
`default_nettype wire

/* File: mlp_properties.sv */
// Concurrent checks on the load link and the load port outputs
`timescale 1ns/1ps
`default_nettype none
module mlp_properties
   import mlp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       wr_stb,
   input  wire logic       rd_stb,
   input  wire logic       rd_valid,
   input  wire logic [7:0] reg_addr,
   input  wire logic       mem_we_o,
   input  wire logic [3:0] mem_sel_o,
   input  wire logic       load_done_o,
   input  wire logic       load_ok_o,
   input  wire logic       session_end_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   rd_answer_a: assert property (rd_stb |=> rd_valid)
      else $error("status byte not answered");
   we_cause_a: assert property (mem_we_o |-> $past(wr_stb) && $past(reg_addr) == REG_PAYLOAD)
      else $error("memory write without payload byte");
   sel_legal_a: assert property (mem_we_o |-> mem_sel_o <= MEM_LAST)
      else $error("write to reserved memory");
   ok_in_done_a: assert property (load_ok_o |-> load_done_o)
      else $error("load ok outside load done");
   done_cause_a: assert property (load_done_o |-> $past(wr_stb) && $past(reg_addr) == REG_PAYLOAD)
      else $error("load done without closing byte");
   done_pulse_a: assert property (load_done_o |=> !load_done_o)
      else $error("load done longer than a cycle");
   end_no_we_a: assert property (session_end_o |-> !mem_we_o ##1 !mem_we_o)
      else $error("memory written on session end");
   end_cause_a: assert property (session_end_o |-> $past(wr_stb) && $past(reg_addr) == REG_HEADER)
      else $error("session end without header byte");
endmodule
`default_nettype wire

/* File: mlp_tb_top.sv */
// Testbench: host end and load port joined over the link
`timescale 1ns/1ps
`default_nettype none
module mlp_tb_top;
   import mlp_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, ack, irq, we_o, done, ok, send;
   logic [3:0]  sel, msel;
   logic [6:0]  fw_clr;
   logic [7:0]  adr;
   logic [15:0] maddr;
   logic [23:0] fw_hi;
   logic        fw_div;
   logic [31:0] dat_w, dat_r, q, st;
   logic [63:0] wdat, last_wd;
   integer      fail_count, num_checks, we_cnt, end_cnt, ok_cnt;
   localparam logic [63:0] D = 64'h0F1E_2D3C_4B5A_6978;
   mlp_link_if link ();
   mlp_host i_mlp_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
      .wb_ack_o(ack), .irq_o(irq), .link(link));
   mlp_device i_mlp_device (.clk_i(clk_i), .rst_i(rst_i), .link(link), .mem_we_o(we_o),
      .mem_sel_o(msel), .mem_addr_o(maddr), .mem_wdata_o(wdat), .fw_clr_i(fw_clr),
      .fw_status_hi_i(fw_hi), .fw_div_report_i(fw_div), .load_active_o(),
      .load_done_o(done), .load_ok_o(ok), .session_end_o(send));
   mlp_properties i_mlp_properties (.clk_i(clk_i), .rst_i(rst_i), .wr_stb(link.wr_stb),
      .rd_stb(link.rd_stb), .rd_valid(link.rd_valid), .reg_addr(link.reg_addr),
      .mem_we_o(we_o), .mem_sel_o(msel), .load_done_o(done), .load_ok_o(ok),
      .session_end_o(send));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (we_o === 1'b1) begin
         we_cnt++;
         last_wd = wdat;
      end
      if (send === 1'b1) end_cnt++;
      if (ok === 1'b1) ok_cnt++;
   end
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
      num_checks++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer n;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = dat_r;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (n >= 50) chk("wb_ack", 64'h1, 64'h0);
   endtask
   task automatic cmd(input logic [1:0] op, input logic [7:0] r, input logic [7:0] d);
      integer n;
      wb(1'b1, WB_CMD, {14'h0, op, r, d});
      n = 0;
      do begin
         wb(1'b0, WB_STATE, 32'h0);
         n++;
      end while (q[0] !== 1'b0 && n < 40);
   endtask
   task automatic rd_st();
      cmd(OP_START, REG_STATUS, 8'h00);
      st = 32'h0;
      repeat (4) begin
         cmd(OP_READ, REG_STATUS, 8'h00);
         wb(1'b0, WB_RXDATA, 32'h0);
         st = {st[23:0], q[7:0]};
      end
   endtask
   task automatic hdr(input logic [63:0] h);
      cmd(OP_START, REG_HEADER, 8'h00);
      for (int i = 0; i < 8; i++) cmd(OP_WRITE, REG_HEADER, h[63-8*i -: 8]);
   endtask
   task automatic load(input logic [3:0] m, input logic bad, input int fb);
      logic [15:0] cs;
      cs = {12'h0, m} + 16'h0012 + 16'h0008;
      for (int i = 0; i < 8; i++) cs = cs + {8'h00, D[63-8*i -: 8]};
      if (bad) cs = ~cs;
      we_cnt = 0;
      ok_cnt = 0;
      hdr({cs, 4'h0, m, 8'h00, 16'h0012, 16'h0008});
      rd_st();
      chk("flag_on_start", 64'h1, {63'h0, st[fb]});
      cmd(OP_START, REG_PAYLOAD, 8'h00);
      for (int i = 0; i < 8; i++) cmd(OP_WRITE, REG_PAYLOAD, D[63-8*i -: 8]);
      cmd(OP_WRITE, REG_PAYLOAD, cs[15:8]);
      cmd(OP_WRITE, REG_PAYLOAD, cs[7:0]);
      rd_st();
   endtask
   task automatic t_all_mems();
      logic [63:0] e;
      int          nw, fb;
      for (int m = 0; m < 7; m++) begin
         case (m)
            0, 1: begin e = D & MASK_8; nw = 8; fb = m; end
            2: begin e = D & MASK_54; nw = 1; fb = ST_DSP_PROG; end
            4, 5: begin e = D & MASK_48; nw = 1; fb = ST_UP_DATA; end
            default: begin e = D & MASK_28; nw = 2; fb = ST_UP_COEF; end
         endcase
         load(m[3:0], 1'b0, fb);
         chk("flag_cleared", 64'h0, {63'h0, st[fb]});
         chk("load_ok", 64'h1, ok_cnt);
         chk("word_count", nw, we_cnt);
         chk("last_word", e, last_wd);
         chk("mem_sel", m, msel);
         chk("mem_addr", 64'h12, maddr);
      end
   endtask
   task automatic t_bad_sum();
      load(MEM_MCU_XDATA, 1'b1, ST_MCU_XDATA);
      chk("flag_kept", 64'h1, {63'h0, st[ST_MCU_XDATA]});
      chk("no_load_ok", 64'h0, ok_cnt);
      @(posedge clk_i);
      fw_clr <= 7'h02;
      @(posedge clk_i);
      fw_clr <= 7'h00;
      rd_st();
      chk("fw_clear", 64'h0, {63'h0, st[ST_MCU_XDATA]});
   endtask
   task automatic t_term_resv();
      we_cnt = 0;
      end_cnt = 0;
      hdr(64'h0);
      chk("session_end", 64'h1, end_cnt);
      chk("no_write", 64'h0, we_cnt);
      rd_st();
      chk("no_errors", 64'h0, st[7:0]);
      hdr({16'h0007, 4'h0, 4'h7, 24'h0, 16'h0001});
      rd_st();
      chk("bad_sel", 64'h20, st[7:0]);
      chk("reserved_no_write", 64'h0, we_cnt);
      hdr({16'h1234, 48'h0});
      rd_st();
      chk("end_hdr_err", 64'hF0, st[7:0]);
   endtask
   task automatic t_fw_irq();
      fw_hi <= 24'hA5C3E1;
      fw_div <= 1'b1;
      rd_st();
      chk("div_report", {32'h0, 24'hA5C3E1, 8'hFF}, st);
      fw_div <= 1'b0;
      rd_st();
      chk("fw_high", 64'hA5C3E1, st[31:8]);
      wb(1'b1, WB_IRQ_STAT, 32'h7);
      wb(1'b1, WB_IRQ_MASK, 32'h1);
      cmd(OP_START, REG_STATUS, 8'h00);
      chk("irq_raised", 64'h1, irq);
      wb(1'b1, WB_IRQ_STAT, 32'h1);
      chk("irq_cleared", 64'h0, irq);
      wb(1'b1, WB_IRQ_MASK, 32'h0);
      cmd(OP_START, REG_STATUS, 8'h00);
      chk("irq_masked", 64'h0, irq);
      wb(1'b0, WB_IRQ_STAT, 32'h0);
      chk("irq_sticky", 64'h1, q[IRQ_DONE]);
      wb(1'b0, 8'hFC, 32'h0);
      chk("unmapped", 64'h0, q);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk_i);
      fail_count++;
      end_of_test();
   end
   initial begin
      fail_count = 0; num_checks = 0; we_cnt = 0; end_cnt = 0; ok_cnt = 0;
      cyc = 0; stb = 0; we = 0; adr = 0; sel = 4'hF; dat_w = 0;
      fw_clr = 0; fw_hi = 0; fw_div = 0; rst_i = 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_all_mems();
      t_bad_sum();
      t_term_resv();
      t_fw_irq();
      end_of_test();
   end
endmodule
`default_nettype wire
